/* include/fpc_pkg.sv */
// Shared constants for the coprocessor register file and data-move block.
package fpc_pkg;
  // Coprocessor select window on the upper address half.
  localparam logic [15:0] SEL_LO = 16'hC000;
  localparam logic [15:0] SEL_HI = 16'hC1FF;
  // Address field positions.
  localparam int SEL_POS = 16;
  localparam int OP_POS = 10;
  localparam int OP_W = 6;
  localparam int S1HI_POS = 7;
  localparam int DST_POS = 2;
  localparam int REG_W = 5;
  localparam int NREGS = 32;
  // Context register fields.
  localparam int RMODE_POS = 26;
  localparam int MASK_POS = 16;
  localparam int MASK_W = 10;
  localparam int ACC_POS = 0;
  localparam int ACC_W = 6;
  localparam int EXC_INEXACT = 0;
  localparam int EXC_INVALID = 1;
  localparam int EXC_OVERFLOW = 2;
  localparam logic [31:0] CTX_RESET = 32'h03FF0000;
  // Rounding modes.
  typedef enum logic [1:0] {
    RND_NEAREST = 2'b00,
    RND_ZERO = 2'b01,
    RND_UP = 2'b10,
    RND_DOWN = 2'b11
  } fpc_rmode_t;
  // Operation codes carried in the opcode field.
  typedef enum logic [5:0] {
    OP_LOAD = 6'h00,
    OP_LOAD_D = 6'h01,
    OP_LOAD_CTX = 6'h02,
    OP_POP = 6'h03,
    OP_POP_D = 6'h04,
    OP_BLOCK_LD = 6'h05,
    OP_STORE = 6'h06,
    OP_STORE_CTX = 6'h07,
    OP_PUSH = 6'h08,
    OP_PUSH_D = 6'h09,
    OP_BLOCK_ST = 6'h0A,
    OP_REV = 6'h0B,
    OP_ITOF_S = 6'h0C,
    OP_ITOF_D = 6'h0D,
    OP_FTOI_S = 6'h0E,
    OP_FTOI_D = 6'h0F,
    OP_CVT_DS = 6'h10,
    OP_CVT_SD = 6'h11
  } fpc_op_t;
endpackage

/* hw/fpc_conv.sv */
// Combinational integer, single and double format converter.
module fpc_conv (
  input wire logic [5:0] op, // Conversion opcode.
  input wire logic [63:0] opnd, // Operand, single or integer in the high word.
  input wire logic [1:0] rmode, // Current rounding mode.
  output logic [63:0] res, // Result, single or integer in the high word.
  output logic [2:0] exc // Inexact, invalid, overflow events.
);
  logic sgn;
  logic [31:0] mag;
  logic [31:0] nrm;
  logic [4:0] lz;
  logic [7:0] pos;
  logic [31:0] sum;
  logic [63:0] dbl;
  logic [10:0] e;
  logic [12:0] ne;
  logic [5:0] sh;
  logic [116:0] wide;
  logic [31:0] ip;
  logic up;

  function automatic logic rnd_up(input logic s, input logic lsb, input logic g,
                                  input logic st, input logic [1:0] m);
    case (m)
      fpc_pkg::RND_NEAREST: rnd_up = g & (st | lsb);
      fpc_pkg::RND_UP: rnd_up = ~s & (g | st);
      fpc_pkg::RND_DOWN: rnd_up = s & (g | st);
      default: rnd_up = 1'b0;
    endcase
  endfunction

  // Widening of normal values is exact, so it needs no rounding; a denormal single is flushed to a signed zero.
  function automatic logic [63:0] widen(input logic [31:0] f);
    if (f[30:23] == 8'h00) begin
      widen = {f[31], 63'h0};
    end else if (f[30:23] == 8'hFF) begin
      widen = {f[31], 11'h7FF, f[22:0], 29'h0};
    end else begin
      widen = {f[31], 3'h0, f[30:23], f[22:0], 29'h0} + {1'b0, 11'h380, 52'h0};
    end
  endfunction

  always_comb begin
    res = 64'h0;
    exc = 3'h0;
    sgn = opnd[63];
    mag = opnd[63] ? 32'(-opnd[63:32]) : opnd[63:32];
    lz = 5'h00;
    for (int i = 0; i < 32; i++) begin
      if (mag[i]) begin
        lz = 5'(31 - i);
      end
    end
    nrm = mag << lz;
    pos = 8'(31 - lz);
    dbl = (op == fpc_pkg::OP_FTOI_S) ? widen(opnd[63:32]) : opnd;
    e = dbl[62:52];
    ne = {2'h0, e} - 13'h0380;
    sh = 6'(11'h433 - e);
    wide = {1'b1, dbl[51:0], 64'h0} >> sh;
    ip = wide[95:64];
    up = 1'b0;
    sum = 32'h0;
    case (op)
      fpc_pkg::OP_ITOF_S: begin
        if (mag != 32'h0) begin
          up = rnd_up(sgn, nrm[8], nrm[7], |nrm[6:0], rmode);
          sum = {1'b0, pos + 8'h7F, nrm[30:8]} + {31'h0, up};
          res = {sgn, sum[30:0], 32'h0};
          exc[fpc_pkg::EXC_INEXACT] = |nrm[7:0];
        end
      end
      fpc_pkg::OP_ITOF_D: begin
        if (mag != 32'h0) begin
          // The exponent is formed at full width so that the bias cannot wrap.
          res = {sgn, 11'(pos) + 11'h3FF, nrm[30:0], 21'h0};
        end
      end
      fpc_pkg::OP_FTOI_S, fpc_pkg::OP_FTOI_D: begin
        if (e >= 11'h41E) begin
          // Out of range or NaN saturates to the most negative integer.
          res = {32'h80000000, 32'h0};
          exc[fpc_pkg::EXC_INVALID] = 1'b1;
        end else if (e < 11'h3FE) begin
          up = rnd_up(dbl[63], 1'b0, 1'b0, |dbl[62:0], rmode);
          res = {dbl[63] ? 32'(-{31'h0, up}) : {31'h0, up}, 32'h0};
          exc[fpc_pkg::EXC_INEXACT] = |dbl[62:0];
        end else begin
          up = rnd_up(dbl[63], ip[0], wide[63], |wide[62:0], rmode);
          sum = ip + {31'h0, up};
          res = {dbl[63] ? 32'(-sum) : sum, 32'h0};
          exc[fpc_pkg::EXC_INEXACT] = |wide[63:0];
        end
      end
      fpc_pkg::OP_CVT_DS: begin
        if (e == 11'h000) begin
          res = {dbl[63], 63'h0};
        end else if (e == 11'h7FF) begin
          res = {dbl[63], 8'hFF, |dbl[51:0], 22'h0, 32'h0};
        end else if (!ne[12] && ne >= 13'h00FF) begin
          res = {dbl[63], 8'hFF, 23'h0, 32'h0};
          exc[fpc_pkg::EXC_OVERFLOW] = 1'b1;
          exc[fpc_pkg::EXC_INEXACT] = 1'b1;
        end else if (ne[12] || ne == 13'h0000) begin
          // Underflow flushes to a signed zero.
          res = {dbl[63], 63'h0};
          exc[fpc_pkg::EXC_INEXACT] = 1'b1;
        end else begin
          up = rnd_up(dbl[63], dbl[29], dbl[28], |dbl[27:0], rmode);
          sum = {1'b0, ne[7:0], dbl[51:29]} + {31'h0, up};
          res = {dbl[63], sum[30:0], 32'h0};
          exc[fpc_pkg::EXC_INEXACT] = |dbl[28:0];
          exc[fpc_pkg::EXC_OVERFLOW] = (sum[30:23] == 8'hFF);
        end
      end
      fpc_pkg::OP_CVT_SD: begin
        res = widen(opnd[63:32]);
      end
      default: begin
        res = 64'h0;
      end
    endcase
  end
endmodule

/* hw/fpc_regs.sv */
// Register file, context register and data-move decoder of the coprocessor.
module fpc_regs #(
  parameter logic [7:0] REVISION = 8'h01 // Revision level; value is arbitrary.
) (
  input wire logic clk_sys, // System clock.
  input wire logic rst, // Asynchronous reset, active high.
  input wire logic hst_req, // One-cycle access strobe from the host bus.
  input wire logic hst_we, // High for a host write, low for a read.
  input wire logic [31:0] hst_addr, // Physical address of the access.
  input wire logic [31:0] hst_wdata, // Host write data.
  output logic hst_ack, // One-cycle answer to a decoded access.
  output logic [31:0] hst_rdata, // Read data, valid with the answer.
  output logic [1:0] round_mode, // Rounding mode now in force.
  output logic exc_pending // An unmasked accumulated exception is present.
);
  logic [31:0] fregs [fpc_pkg::NREGS];
  logic [31:0] process_context;
  logic sel;
  logic [5:0] op;
  logic [4:0] first_source;
  logic [4:0] second_source_dest;
  logic [4:0] d_even;
  logic [4:0] d_odd;
  logic [4:0] s_even;
  logic [4:0] s_odd;
  logic [31:0] s1_val;
  logic [63:0] s1_dbl;
  logic [10:0] key;
  logic [10:0] last_key;
  logic last_valid;
  logic [4:0] seq;
  logic [4:0] seq_cnt;
  logic [4:0] blk_reg;
  logic [63:0] conv_in;
  logic [63:0] conv_res;
  logic [2:0] conv_exc;
  logic is_conv;
  logic dbl_dest;
  logic [31:0] next_rdata;

  // The select window covers upper address half values SEL_LO through SEL_HI only.
  assign sel = hst_req && hst_addr[31:fpc_pkg::SEL_POS] >= fpc_pkg::SEL_LO
    && hst_addr[31:fpc_pkg::SEL_POS] <= fpc_pkg::SEL_HI;

  // The first source is split so that the two low address bits can step
  // through a block without touching the other fields.
  assign op = hst_addr[fpc_pkg::OP_POS +: fpc_pkg::OP_W];
  assign first_source = {hst_addr[fpc_pkg::S1HI_POS +: 3], hst_addr[1:0]};
  assign second_source_dest = hst_addr[fpc_pkg::DST_POS +: fpc_pkg::REG_W];

  assign d_even = {second_source_dest[4:1], 1'b0};
  assign d_odd = {second_source_dest[4:1], 1'b1};
  assign s_even = {first_source[4:1], 1'b0};
  assign s_odd = {first_source[4:1], 1'b1};

  // Register zero is never read as a single source; its code means bus data.
  assign s1_val = (first_source == 5'h00) ? hst_wdata : fregs[first_source];

  // A double from the bus pairs the host word with register one as low word.
  assign s1_dbl = (first_source == 5'h00) ? {hst_wdata, fregs[1]}
    : {fregs[s_even], fregs[s_odd]};

  // Consecutive accesses with the same opcode and destination form one
  // sequence; its index picks the pair half or the block element.
  assign key = {op, second_source_dest};
  assign seq = (last_valid && key == last_key) ? seq_cnt : 5'h00;
  assign blk_reg = 5'(second_source_dest + seq);

  always_comb begin
    is_conv = 1'b0;
    dbl_dest = 1'b0;
    conv_in = {s1_val, 32'h0};
    case (op)
      fpc_pkg::OP_ITOF_S, fpc_pkg::OP_FTOI_S: begin
        is_conv = 1'b1;
      end
      fpc_pkg::OP_ITOF_D, fpc_pkg::OP_CVT_SD: begin
        is_conv = 1'b1;
        dbl_dest = 1'b1;
      end
      fpc_pkg::OP_FTOI_D, fpc_pkg::OP_CVT_DS: begin
        is_conv = 1'b1;
        conv_in = s1_dbl;
      end
      default: begin
        is_conv = 1'b0;
      end
    endcase
  end

  fpc_conv fpc_conv_i (
    .op(op),
    .opnd(conv_in),
    .rmode(process_context[fpc_pkg::RMODE_POS +: 2]),
    .res(conv_res),
    .exc(conv_exc)
  );

  // Register file writes; only host writes change register contents.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < fpc_pkg::NREGS; i++) begin
        fregs[i] <= 32'h0;
      end
    end else if (sel && hst_we) begin
      case (op)
        fpc_pkg::OP_LOAD: begin
          fregs[second_source_dest] <= s1_val;
        end
        fpc_pkg::OP_LOAD_D: begin
          fregs[d_even] <= s1_dbl[63:32];
          fregs[d_odd] <= s1_dbl[31:0];
        end
        fpc_pkg::OP_POP: begin
          fregs[second_source_dest] <= hst_wdata;
        end
        fpc_pkg::OP_POP_D: begin
          // The first popped word is the high word of the pair.
          if (seq[0]) begin
            fregs[d_odd] <= hst_wdata;
          end else begin
            fregs[d_even] <= hst_wdata;
          end
        end
        fpc_pkg::OP_BLOCK_LD: begin
          fregs[blk_reg] <= hst_wdata;
        end
        default: begin
          if (is_conv && dbl_dest) begin
            fregs[d_even] <= conv_res[63:32];
            fregs[d_odd] <= conv_res[31:0];
          end else if (is_conv) begin
            fregs[second_source_dest] <= conv_res[63:32];
          end
        end
      endcase
    end
  end

  // Context register. Conversion events accumulate as sticky status bits;
  // a load replaces the whole word, so software restores a saved context
  // exactly as it was read.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      process_context <= fpc_pkg::CTX_RESET;
    end else if (sel && hst_we && op == fpc_pkg::OP_LOAD_CTX) begin
      process_context <= hst_wdata;
    end else if (sel && hst_we && is_conv) begin
      process_context[fpc_pkg::ACC_POS +: 3] <=
        process_context[fpc_pkg::ACC_POS +: 3] | conv_exc;
    end
  end

  // Sequence tracking for pair and block transfers.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      last_key <= 11'h000;
      last_valid <= 1'b0;
      seq_cnt <= 5'h00;
    end else if (sel) begin
      last_key <= key;
      last_valid <= 1'b1;
      seq_cnt <= 5'(seq + 5'h01);
    end
  end

  // Read data. Store variants that name a host opcode return the plain
  // value; the combination takes place in the host.
  always_comb begin
    next_rdata = 32'h0;
    case (op)
      fpc_pkg::OP_STORE, fpc_pkg::OP_PUSH: begin
        next_rdata = fregs[second_source_dest];
      end
      fpc_pkg::OP_STORE_CTX: begin
        next_rdata = process_context;
      end
      fpc_pkg::OP_PUSH_D: begin
        next_rdata = seq[0] ? fregs[d_odd] : fregs[d_even];
      end
      fpc_pkg::OP_BLOCK_ST: begin
        next_rdata = fregs[blk_reg];
      end
      fpc_pkg::OP_REV: begin
        next_rdata = {24'h0, REVISION};
      end
      default: begin
        next_rdata = 32'h0;
      end
    endcase
  end

  // Accesses outside the window get no answer at all, so another device
  // on the bus may claim them.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      hst_ack <= 1'b0;
      hst_rdata <= 32'h0;
    end else begin
      hst_ack <= sel;
      if (sel && !hst_we) begin
        hst_rdata <= next_rdata;
      end
    end
  end

  assign round_mode = process_context[fpc_pkg::RMODE_POS +: 2];
  assign exc_pending = |(process_context[fpc_pkg::ACC_POS +: 3]
    & ~process_context[fpc_pkg::MASK_POS +: 3]);
endmodule

/* bench/fpc_regs_monitor.sv */
// Concurrent checks on the ports of the coprocessor register block.
module fpc_regs_monitor #(
  parameter logic [7:0] REVISION = 8'h01 // Revision level; value is arbitrary.
) (
  input wire logic clk_sys, // System clock.
  input wire logic rst, // Asynchronous reset, active high.
  input wire logic hst_req, // Access strobe.
  input wire logic hst_we, // Write when high.
  input wire logic [31:0] hst_addr, // Access address.
  input wire logic [31:0] hst_wdata, // Write data.
  input wire logic hst_ack, // Answer pulse.
  input wire logic [31:0] hst_rdata, // Read data.
  input wire logic [1:0] round_mode, // Rounding mode in force.
  input wire logic exc_pending // Unmasked exception present.
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  logic sel;
  logic taken;
  logic [5:0] opc;
  logic [31:0] ctx_m;
  assign sel = hst_addr[31:16] >= fpc_pkg::SEL_LO && hst_addr[31:16] <= fpc_pkg::SEL_HI;
  assign taken = hst_req && sel;
  assign opc = hst_addr[15:10];
  // Shadow of the last loaded context; the status bits are left out of comparisons
  // because conversions may raise them behind our back.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ctx_m <= fpc_pkg::CTX_RESET;
    end else if (taken && hst_we && opc == fpc_pkg::OP_LOAD_CTX) begin
      ctx_m <= hst_wdata;
    end
  end
  chk_ack_taken: assert property (taken |=> hst_ack)
    else $error("no answer to a decoded access");
  chk_ack_quiet: assert property (!taken |=> !hst_ack)
    else $error("answer without a decoded access");
  chk_rev_value: assert property (taken && !hst_we && opc == fpc_pkg::OP_REV
    |=> hst_rdata == {24'h000000, REVISION}) else $error("wrong revision word");
  chk_round_track: assert property (round_mode == ctx_m[27:26])
    else $error("rounding mode differs from loaded context");
  chk_ctx_readback: assert property (taken && !hst_we && opc == fpc_pkg::OP_STORE_CTX
    |=> hst_rdata[31:6] == ctx_m[31:6]) else $error("context read differs");
  chk_exc_load: assert property (taken && hst_we && opc == fpc_pkg::OP_LOAD_CTX
    |=> exc_pending == |($past(hst_wdata[2:0]) & ~$past(hst_wdata[18:16])))
    else $error("pending flag wrong after context load");
  chk_masked_quiet: assert property (&ctx_m[18:16] |-> !exc_pending)
    else $error("masked exception reported");
  chk_rdata_hold: assert property (!(taken && !hst_we) |=> $stable(hst_rdata))
    else $error("read data moved without a read");
  chk_undef_zero: assert property (taken && !hst_we && opc > 6'h11
    |=> hst_rdata == 32'h00000000) else $error("undefined opcode read not zero");
  cover property (taken && !hst_we && opc == fpc_pkg::OP_REV);
  cover property (hst_req && !sel);
  cover property (taken && opc == fpc_pkg::OP_POP_D ##3 taken && opc == fpc_pkg::OP_POP_D);
endmodule
bind fpc_regs fpc_regs_monitor #(.REVISION(REVISION)) fpc_regs_monitor_i (
  .clk_sys(clk_sys), .rst(rst), .hst_req(hst_req), .hst_we(hst_we), .hst_addr(hst_addr),
  .hst_wdata(hst_wdata), .hst_ack(hst_ack), .hst_rdata(hst_rdata),
  .round_mode(round_mode), .exc_pending(exc_pending));

/* bench/fpc_host_model.sv */
// Host processor model issuing memory-mapped coprocessor accesses.
module fpc_host_model (
  input wire logic clk_sys, // System clock.
  input wire logic hst_ack, // Answer pulse.
  input wire logic [31:0] hst_rdata, // Read data.
  output logic hst_req, // Access strobe.
  output logic hst_we, // Write when high.
  output logic [31:0] hst_addr, // Access address.
  output logic [31:0] hst_wdata // Write data.
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    hst_req = 1'b0;
    hst_we = 1'b0;
    hst_addr = 32'h00000000;
    hst_wdata = 32'h00000000;
  end
  // One strobe per word, so pops, pushes and block moves are word sequences; the
  // host does any opcode combining on the returned word itself.
  // Released address and data show the inverse so stale values never look valid.
  task automatic xfer(input logic we, input logic [31:0] a, input logic [31:0] d,
                      input int gap, output logic [31:0] q, output logic ok);
    repeat (gap) @(posedge clk_sys);
    @(posedge clk_sys);
    hst_req <= 1'b1;
    hst_we <= we;
    hst_addr <= a;
    hst_wdata <= d;
    @(posedge clk_sys);
    hst_req <= 1'b0;
    hst_addr <= ~a;
    hst_wdata <= ~d;
    @(posedge clk_sys);
    ok = hst_ack;
    q = hst_rdata;
  endtask
endmodule

/* bench/fpc_regs_tb.sv */
// Self-checking bench for the coprocessor register file and data moves.
module fpc_regs_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] REV = 8'h5A; // Arbitrary revision level.
  logic clk_sys;
  logic rst;
  logic hst_req, hst_we, hst_ack, exc_pending, ok;
  logic [31:0] hst_addr, hst_wdata, hst_rdata, q;
  logic [1:0] round_mode;
  int errors = 0;
  int checked = 0;
  int gap = 0;
  fpc_regs #(.REVISION(REV)) fpc_regs_i (.clk_sys(clk_sys), .rst(rst), .hst_req(hst_req),
    .hst_we(hst_we), .hst_addr(hst_addr), .hst_wdata(hst_wdata), .hst_ack(hst_ack),
    .hst_rdata(hst_rdata), .round_mode(round_mode), .exc_pending(exc_pending));
  fpc_host_model fpc_host_model_i (.clk_sys(clk_sys), .hst_ack(hst_ack),
    .hst_rdata(hst_rdata), .hst_req(hst_req), .hst_we(hst_we), .hst_addr(hst_addr),
    .hst_wdata(hst_wdata));
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  function automatic logic [31:0] adr(logic [5:0] op, logic [4:0] dst, logic [4:0] src);
    return {16'hC000, op, src[4:2], dst, src[1:0]};
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    checked++;
    if (seen !== want) begin
      errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, seen, want);
    end
  endtask
  task automatic wr(input logic [5:0] op, input logic [4:0] dst, input logic [4:0] src,
                    input logic [31:0] d);
    fpc_host_model_i.xfer(1'b1, adr(op, dst, src), d, gap, q, ok);
    chk({31'h0, ok}, 32'h00000001);
  endtask
  task automatic rdv(input logic [5:0] op, input logic [4:0] dst, input logic [31:0] want);
    fpc_host_model_i.xfer(1'b0, adr(op, dst, 5'h00), 32'h00000000, gap, q, ok);
    chk({31'h0, ok}, 32'h00000001);
    chk(q, want);
  endtask
  task automatic t_reset_vals;
    rdv(fpc_pkg::OP_STORE_CTX, 5'h00, fpc_pkg::CTX_RESET);
    chk({30'h0, round_mode}, 32'h00000000);
    rdv(fpc_pkg::OP_STORE, 5'h06, 32'h00000000);
  endtask
  task automatic t_all_regs;
    for (int r = 0; r < 32; r++) wr(fpc_pkg::OP_LOAD, r[4:0], 5'h00, 32'hA5000000 | r);
    gap = 2;
    for (int r = 0; r < 32; r++) rdv(fpc_pkg::OP_STORE, r[4:0], 32'hA5000000 | r);
    gap = 0;
    wr(fpc_pkg::OP_LOAD, 5'h14, 5'h05, 32'h00000000);
    rdv(fpc_pkg::OP_STORE, 5'h14, 32'hA5000005);
  endtask
  task automatic t_stack;
    wr(fpc_pkg::OP_POP_D, 5'h06, 5'h00, 32'h11111111);
    wr(fpc_pkg::OP_POP_D, 5'h06, 5'h00, 32'h22222222);
    rdv(fpc_pkg::OP_STORE, 5'h06, 32'h11111111);
    rdv(fpc_pkg::OP_STORE, 5'h07, 32'h22222222);
    wr(fpc_pkg::OP_LOAD_D, 5'h12, 5'h06, 32'h00000000);
    rdv(fpc_pkg::OP_STORE, 5'h12, 32'h11111111);
    rdv(fpc_pkg::OP_STORE, 5'h13, 32'h22222222);
    rdv(fpc_pkg::OP_PUSH_D, 5'h06, 32'h11111111);
    rdv(fpc_pkg::OP_PUSH_D, 5'h06, 32'h22222222);
    wr(fpc_pkg::OP_POP, 5'h09, 5'h00, 32'h33333333);
    rdv(fpc_pkg::OP_PUSH, 5'h09, 32'h33333333);
    rdv(fpc_pkg::OP_STORE, 5'h08, 32'hA5000008);
  endtask
  task automatic t_block;
    for (int i = 0; i < 4; i++) wr(fpc_pkg::OP_BLOCK_LD, 5'h0C, 5'h00, 32'hB0 + i);
    for (int i = 0; i < 4; i++) rdv(fpc_pkg::OP_BLOCK_ST, 5'h0C, 32'hB0 + i);
    rdv(fpc_pkg::OP_STORE, 5'h10, 32'hA5000010);
  endtask
  task automatic t_ctx;
    wr(fpc_pkg::OP_LOAD_CTX, 5'h00, 5'h00, 32'h08000005);
    chk({30'h0, round_mode}, 32'h00000002);
    chk({31'h0, exc_pending}, 32'h00000001);
    rdv(fpc_pkg::OP_STORE_CTX, 5'h00, 32'h08000005);
    wr(fpc_pkg::OP_LOAD_CTX, 5'h00, 5'h00, 32'h03FF0000);
    chk({30'h0, round_mode}, 32'h00000000);
    chk({31'h0, exc_pending}, 32'h00000000);
  endtask
  task automatic t_conv;
    wr(fpc_pkg::OP_LOAD, 5'h01, 5'h00, 32'h00000000);
    wr(fpc_pkg::OP_ITOF_S, 5'h02, 5'h00, 32'h00000001);
    rdv(fpc_pkg::OP_STORE, 5'h02, 32'h3F800000);
    wr(fpc_pkg::OP_ITOF_D, 5'h0E, 5'h00, 32'hFFFFFFFE);
    rdv(fpc_pkg::OP_STORE, 5'h0E, 32'hC0000000);
    rdv(fpc_pkg::OP_STORE, 5'h0F, 32'h00000000);
    wr(fpc_pkg::OP_FTOI_D, 5'h03, 5'h0E, 32'h00000000);
    rdv(fpc_pkg::OP_STORE, 5'h03, 32'hFFFFFFFE);
    wr(fpc_pkg::OP_FTOI_S, 5'h04, 5'h00, 32'h40200000);
    rdv(fpc_pkg::OP_STORE, 5'h04, 32'h00000002);
    wr(fpc_pkg::OP_LOAD_CTX, 5'h00, 5'h00, 32'h0BFF0000);
    wr(fpc_pkg::OP_FTOI_S, 5'h04, 5'h00, 32'h40200000);
    rdv(fpc_pkg::OP_STORE, 5'h04, 32'h00000003);
    wr(fpc_pkg::OP_ITOF_S, 5'h08, 5'h04, 32'h00000000);
    rdv(fpc_pkg::OP_STORE, 5'h08, 32'h40400000);
    wr(fpc_pkg::OP_CVT_SD, 5'h0A, 5'h00, 32'h3F800000);
    rdv(fpc_pkg::OP_STORE, 5'h0A, 32'h3FF00000);
    rdv(fpc_pkg::OP_STORE, 5'h0B, 32'h00000000);
    wr(fpc_pkg::OP_CVT_DS, 5'h05, 5'h00, 32'h3FF80000);
    rdv(fpc_pkg::OP_STORE, 5'h05, 32'h3FC00000);
    rdv(fpc_pkg::OP_STORE_CTX, 5'h00, 32'h0BFF0001);
  endtask
  task automatic t_decode;
    fpc_host_model_i.xfer(1'b1, 32'hC2000000 | adr(6'h00, 5'h02, 5'h00), 32'h0, 0, q, ok);
    chk({31'h0, ok}, 32'h00000000);
    rdv(fpc_pkg::OP_STORE, 5'h02, 32'h3F800000);
    fpc_host_model_i.xfer(1'b0, {16'hC1FF, fpc_pkg::OP_REV, 10'h000}, 32'h0, 0, q, ok);
    chk({31'h0, ok}, 32'h00000001);
    chk(q, {24'h000000, REV});
    rdv(6'h3F, 5'h00, 32'h00000000);
  endtask
  task automatic t_reset_again;
    rst <= 1'b1;
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    t_reset_vals();
  endtask
  task automatic wrap_up;
    if (errors == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // The run needs about 450 cycles; the limit leaves ample room.
  initial begin
    repeat (20000) @(posedge clk_sys);
    errors++;
    wrap_up();
  end
  initial begin
    rst = 1'b1;
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    t_reset_vals();
    t_all_regs();
    t_stack();
    t_block();
    t_ctx();
    t_conv();
    t_decode();
    t_reset_again();
    wrap_up();
  end
endmodule
